// file: logic/ctm_pkg.sv
// Constants, field layouts and encodings for the compact timer
//
// Behaviour
// RQ1 - Mode 11 counts and flags exactly like compare mode but leaves the pin undriven.
// RQ2 - Timer/counter mode releases the output pin for other pin functions.
// RQ3 - Writing mode field 10 selects PWM output mode.
// RQ4 - In PWM mode the clear source bit is ignored; only the period compare clears.
// RQ5 - In PWM one compare sets period, the other duty; swap bit picks which.
// RQ6 - In PWM each comparator match sets its own flag.
// RQ7 - In PWM the level bit picks active high or low; pin field passes or forces.
// RQ8 - The invert bit inverts the waveform presented on the pin.
// RQ9 - Swap clear: compare P times 128 is the period, zero means 1024; A is duty.
// RQ10 - Duty at or above period keeps the output active the whole period.
// RQ11 - Swap set: compare A is the period, compare P times 128 the duty.
// RQ12 - Each period compare clear starts a new PWM period.
// RQ13 - PWM counting and comparing continue while the pin is forced.
// RQ14 - In compare mode each run bit rising edge restores the initial pin level.
// RQ15 - In compare mode only comparator A events change the pin.
// RQ16 - Outside PWM mode, with clear source set, comparator P never raises its flag.
// RQ17 - PWM pin field: 00 inactive, 01 active, 10 waveform, 11 undefined.
// RQ18 - Clear source set clears on A; clear clears on P or overflow.
// RQ19 - Compare A match sets, clears, toggles or keeps the pin; level bit is initial.
// RQ20 - Compare A zero in compare mode wraps at 3FF with no A flag.
// RQ21 - Counter steps once per timer tick while running, held at zero when stopped.
`default_nettype none
package ctm_pkg;
  localparam int CTM_CNT_W = 10;
  localparam int CTM_DW = 8;
  localparam int CTM_AW = 3;
  localparam int CTM_HI_W = CTM_CNT_W - CTM_DW;
  localparam int CTM_P_W = 3;
  localparam int CTM_EXT_W = CTM_CNT_W + 1;
  localparam int CTM_PRE_MIN = 3;
  // Period granule and full count of the 10-bit counter
  localparam logic [CTM_EXT_W-1:0] CTM_P_UNIT = 11'h080;
  localparam logic [CTM_EXT_W-1:0] CTM_P_FULL = 11'h400;
  localparam logic [CTM_EXT_W-1:0] CTM_STEP = 11'h001;
  // Register addresses
  localparam logic [CTM_AW-1:0] CTM_A_CTRL0 = 3'h0;
  localparam logic [CTM_AW-1:0] CTM_A_CTRL1 = 3'h1;
  localparam logic [CTM_AW-1:0] CTM_A_CNT_LO = 3'h2;
  localparam logic [CTM_AW-1:0] CTM_A_CNT_HI = 3'h3;
  localparam logic [CTM_AW-1:0] CTM_A_COMPARE_A_VALUE_LO = 3'h4;
  localparam logic [CTM_AW-1:0] CTM_A_COMPARE_A_VALUE_HI = 3'h5;
  localparam logic [CTM_AW-1:0] CTM_A_COMPARE_P_VALUE = 3'h6;
  localparam logic [CTM_AW-1:0] CTM_A_FLAGS = 3'h7;
  // Flag bit positions
  localparam int CTM_FLAG_A = 0;
  localparam int CTM_FLAG_P = 1;
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UND = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TC = 2'h3
  } ctm_mode_type;
  // Pin field codes, compare mode and PWM mode readings
  localparam logic [1:0] CTM_PF_NONE = 2'h0;
  localparam logic [1:0] CTM_PF_LOW = 2'h1;
  localparam logic [1:0] CTM_PF_HIGH = 2'h2;
  localparam logic [1:0] CTM_PF_TOG = 2'h3;
  localparam logic [1:0] CTM_PF_INACT = 2'h0;
  localparam logic [1:0] CTM_PF_ACT = 2'h1;
  localparam logic [1:0] CTM_PF_WAVE = 2'h2;
  typedef struct packed {
    logic [1:0] clk_sel;
    logic timer_run;
  } ctm_ctrl0_type;
  typedef struct packed {
    ctm_mode_type operating_mode_sel;
    logic [1:0] pin_function_sel;
    logic output_level_ctrl;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_sel;
  } ctm_ctrl1_type;
  localparam ctm_ctrl0_type CTM_CTRL0_RST = 3'h0;
  localparam ctm_ctrl1_type CTM_CTRL1_RST = 8'h00;
endpackage : ctm_pkg
`default_nettype wire

// file: logic/ctm_tick.sv
// Timer clock prescaler: one tick every 2^sel clocks while running
`timescale 1ns/1ps
`default_nettype none
module ctm_tick #(
  parameter int PRE_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Tick out
  output logic tick
);
  import ctm_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
  } ctm_tick_state_type;

  ctm_tick_state_type st;
  ctm_tick_state_type next_st;
  logic [PRE_W-1:0] ones;
  logic [PRE_W-1:0] mask;

  if (PRE_W < CTM_PRE_MIN) begin : g_chk
    $error("ctm_tick: PRE_W too small for divide by eight");
  end

  // Low sel bits of the prescaler must all be set for a tick
  always_comb begin
    ones = '1;
    mask = ~(ones << sel);
    tick = run && ((st.pre & mask) == mask);
    next_st = st;
    if (!run) begin
      next_st.pre = '0; // Phase restarts with each run
    end else begin
      next_st.pre = st.pre + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : ctm_tick
`default_nettype wire

// file: logic/ctm_timer.sv
// Compact 10-bit timer with compare-match, timer/counter and PWM modes
`timescale 1ns/1ps
`default_nettype none
module ctm_timer #(
  parameter int PRE_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [ctm_pkg::CTM_AW-1:0] addr,
  input wire logic [ctm_pkg::CTM_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ctm_pkg::CTM_DW-1:0] rdata,
  // Output pin
  output logic timer_output_pin,
  output logic pin_oe_n,
  // Sticky flags
  output logic compare_a_flag,
  output logic compare_p_flag
);
  import ctm_pkg::*;

  typedef struct packed {
    ctm_ctrl0_type c0;
    ctm_ctrl1_type c1;
    logic [CTM_CNT_W-1:0] compare_a_value;
    logic [CTM_P_W-1:0] compare_p_value;
    logic [CTM_CNT_W-1:0] cnt;
    logic run_d;
    logic cm_level;
    logic a_flag;
    logic p_flag;
    logic [CTM_DW-1:0] rdata;
    logic pin;
    logic oe_n;
  } ctm_state_type;

  ctm_state_type st;
  ctm_state_type next_st;

  // Elaboration check on the prescaler width
  if (PRE_W < CTM_PRE_MIN) begin : g_chk
    $error("ctm_timer: PRE_W too small for divide by eight");
  end

  // Decoded controls
  logic tick;
  logic is_pwm;
  logic drives;
  logic run_rise;
  logic [CTM_EXT_W-1:0] n_cnt;
  logic [CTM_EXT_W-1:0] p_val;
  logic [CTM_EXT_W-1:0] a_val;
  logic [CTM_EXT_W-1:0] duty;
  logic [CTM_EXT_W-1:0] period;
  logic a_hit;
  logic p_hit;
  logic per_hit;
  logic a_set;
  logic p_set;
  logic pwm_act;
  logic pwm_lv;
  logic flag_wr;

  // Timer clock source
  ctm_tick #(
    .PRE_W(PRE_W)
  ) u_tick (
    .clk(clk),
    .nrst(nrst),
    .run(st.c0.timer_run),
    .sel(st.c0.clk_sel),
    .tick(tick)
  );

  // Comparator values and matches
  always_comb begin
    is_pwm = st.c1.operating_mode_sel == CTM_MODE_PWM;
    // Only compare mode and PWM mode own the pin
    drives = is_pwm ||
      (st.c1.operating_mode_sel == CTM_MODE_CMP); // [RQ1] [RQ2]
    run_rise = st.c0.timer_run && !st.run_d;
    n_cnt = CTM_EXT_W'(st.cnt) + CTM_STEP;
    // Compare P is in 128-count granules, zero is the full count
    if (st.compare_p_value == '0) begin
      p_val = CTM_P_FULL; // [RQ9]
    end else begin
      p_val = CTM_EXT_W'(st.compare_p_value) * CTM_P_UNIT; // [RQ9]
    end
    if (st.compare_a_value == '0) begin
      a_val = CTM_P_FULL;
    end else begin
      a_val = CTM_EXT_W'(st.compare_a_value);
    end
    // In compare mode a zero compare A never matches
    if (is_pwm) begin
      a_hit = tick && (n_cnt == a_val);
    end else begin
      a_hit = tick && (st.compare_a_value != '0)
        && (n_cnt == a_val); // [RQ20]
    end
    p_hit = tick && (n_cnt == p_val); // [RQ18]
    // Clear source: swap bit in PWM, clear select otherwise
    if (is_pwm) begin
      per_hit = st.c1.period_duty_swap ? a_hit : p_hit; // [RQ4] [RQ5]
    end else begin
      per_hit = st.c1.clear_source_sel ? a_hit : p_hit; // [RQ18]
    end
    a_set = a_hit; // [RQ6]
    p_set = p_hit && (is_pwm || !st.c1.clear_source_sel); // [RQ16] [RQ6]
  end

  // PWM waveform; runs even while the pin is forced
  always_comb begin
    if (st.c1.period_duty_swap) begin
      period = a_val; // [RQ11]
      duty = p_val; // [RQ11]
    end else begin
      period = p_val; // [RQ9]
      duty = CTM_EXT_W'(st.compare_a_value); // [RQ9]
    end
    // Count never reaches period, so duty >= period is always active
    pwm_act = CTM_EXT_W'(st.cnt) < duty; // [RQ10] [RQ13]
    case (st.c1.pin_function_sel)
      CTM_PF_INACT: begin
        pwm_lv = !st.c1.output_level_ctrl; // [RQ17]
      end
      CTM_PF_ACT: begin
        pwm_lv = st.c1.output_level_ctrl; // [RQ17]
      end
      CTM_PF_WAVE: begin
        // Level bit picks active high or active low
        pwm_lv = pwm_act ? st.c1.output_level_ctrl
          : !st.c1.output_level_ctrl; // [RQ7]
      end
      default: begin
        pwm_lv = !st.c1.output_level_ctrl; // Undefined code: idle
      end
    endcase
  end

  // Next state: registers, counter, flags, pin
  always_comb begin
    next_st = st;
    flag_wr = wr && (addr == CTM_A_FLAGS);
    next_st.run_d = st.c0.timer_run;

    // Register writes
    if (wr) begin
      case (addr)
        CTM_A_CTRL0: begin
          next_st.c0 = ctm_ctrl0_type'(wdata[$bits(ctm_ctrl0_type)-1:0]);
        end
        CTM_A_CTRL1: begin
          next_st.c1 = ctm_ctrl1_type'(wdata); // [RQ3]
        end
        CTM_A_COMPARE_A_VALUE_LO: begin
          next_st.compare_a_value[CTM_DW-1:0] = wdata;
        end
        CTM_A_COMPARE_A_VALUE_HI: begin
          next_st.compare_a_value[CTM_CNT_W-1:CTM_DW] =
            wdata[CTM_HI_W-1:0];
        end
        CTM_A_COMPARE_P_VALUE: begin
          next_st.compare_p_value = wdata[CTM_P_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Counter: cleared while stopped, steps on each tick
    if (!st.c0.timer_run) begin
      next_st.cnt = '0; // [RQ21]
    end else if (per_hit) begin
      next_st.cnt = '0; // [RQ12] [RQ4] [RQ18]
    end else if (tick) begin
      next_st.cnt = n_cnt[CTM_CNT_W-1:0]; // [RQ21] [RQ20]
    end

    // Flags clear by writing one; a same-cycle match wins
    if (flag_wr && wdata[CTM_FLAG_A]) begin
      next_st.a_flag = 1'b0;
    end
    if (flag_wr && wdata[CTM_FLAG_P]) begin
      next_st.p_flag = 1'b0;
    end
    if (a_set) begin
      next_st.a_flag = 1'b1; // [RQ6] [RQ1]
    end
    if (p_set) begin
      next_st.p_flag = 1'b1; // [RQ6] [RQ16]
    end

    // Compare-mode pin level; run restart beats a match
    if (run_rise) begin
      next_st.cm_level = st.c1.output_level_ctrl; // [RQ14] [RQ19]
    end else if (a_hit && !is_pwm) begin
      case (st.c1.pin_function_sel)
        CTM_PF_LOW: begin
          next_st.cm_level = 1'b0; // [RQ19]
        end
        CTM_PF_HIGH: begin
          next_st.cm_level = 1'b1; // [RQ19]
        end
        CTM_PF_TOG: begin
          next_st.cm_level = !st.cm_level; // [RQ19]
        end
        default: begin
          next_st.cm_level = st.cm_level; // [RQ19]
        end
      endcase
    end

    // Pin: compare level or PWM level, then optional inversion
    if (is_pwm) begin
      next_st.pin = pwm_lv ^ st.c1.output_invert; // [RQ7] [RQ8]
    end else begin
      // Only comparator A matches and a run restart move the compare level
      next_st.pin = next_st.cm_level ^ st.c1.output_invert; // [RQ15]
    end
    next_st.oe_n = !drives; // [RQ1] [RQ2]

    // Read data stands only in the cycle after the strobe
    next_st.rdata = '0;
    if (rd) begin
      case (addr)
        CTM_A_CTRL0: begin
          next_st.rdata = CTM_DW'(st.c0);
        end
        CTM_A_CTRL1: begin
          next_st.rdata = st.c1;
        end
        CTM_A_CNT_LO: begin
          next_st.rdata = st.cnt[CTM_DW-1:0];
        end
        CTM_A_CNT_HI: begin
          next_st.rdata = CTM_DW'(st.cnt[CTM_CNT_W-1:CTM_DW]);
        end
        CTM_A_COMPARE_A_VALUE_LO: begin
          next_st.rdata = st.compare_a_value[CTM_DW-1:0];
        end
        CTM_A_COMPARE_A_VALUE_HI: begin
          next_st.rdata =
            CTM_DW'(st.compare_a_value[CTM_CNT_W-1:CTM_DW]);
        end
        CTM_A_COMPARE_P_VALUE: begin
          next_st.rdata = CTM_DW'(st.compare_p_value);
        end
        CTM_A_FLAGS: begin
          next_st.rdata[CTM_FLAG_A] = st.a_flag;
          next_st.rdata[CTM_FLAG_P] = st.p_flag;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // State register; pin stays released through reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.c0 <= CTM_CTRL0_RST;
      st.c1 <= CTM_CTRL1_RST;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rdata = st.rdata;
  assign timer_output_pin = st.pin;
  assign pin_oe_n = st.oe_n;
  assign compare_a_flag = st.a_flag;
  assign compare_p_flag = st.p_flag;

  // Checks on the counter, flags and pin
  default clocking ctm_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  tc_release_a: assert property ( // [RQ1] [RQ2]
    (st.c1.operating_mode_sel == CTM_MODE_TC) |=> pin_oe_n)
    else $error("pin driven in timer/counter mode");

  tc_flag_a: assert property ( // [RQ1]
    (st.c1.operating_mode_sel == CTM_MODE_TC) && a_hit
    |=> compare_a_flag)
    else $error("compare A flag missing in timer/counter mode");

  pwm_enter_a: assert property ( // [RQ3]
    wr && (addr == CTM_A_CTRL1)
    && (wdata[CTM_DW-1 -: 2] == CTM_MODE_PWM)
    |=> is_pwm ##1 !pin_oe_n)
    else $error("mode write did not enter PWM");

  pwm_clear_a: assert property ( // [RQ4] [RQ12]
    is_pwm && st.c0.timer_run && tick && (n_cnt == period)
    |=> (st.cnt == '0))
    else $error("PWM period match did not clear counter");

  pwm_pflag_a: assert property ( // [RQ6] [RQ5]
    is_pwm && tick && (n_cnt == p_val) |=> compare_p_flag)
    else $error("PWM compare P flag missing");

  full_duty_a: assert property ( // [RQ10]
    is_pwm && (st.c1.pin_function_sel == CTM_PF_WAVE)
    && (duty >= period) && (CTM_EXT_W'(st.cnt) < period)
    |=> timer_output_pin
      == ($past(st.c1.output_level_ctrl)
      ^ $past(st.c1.output_invert)))
    else $error("PWM not active at full duty");

  force_idle_a: assert property ( // [RQ7] [RQ8] [RQ13]
    is_pwm && (st.c1.pin_function_sel == CTM_PF_INACT)
    && st.c0.timer_run && tick && !per_hit
    |=> (timer_output_pin
      == !($past(st.c1.output_level_ctrl)
      ^ $past(st.c1.output_invert)))
      && (st.cnt != '0))
    else $error("forced inactive PWM pin or stalled counter");

  run_rise_a: assert property ( // [RQ14]
    (st.c1.operating_mode_sel == CTM_MODE_CMP) && run_rise
    |=> timer_output_pin
      == ($past(st.c1.output_level_ctrl)
      ^ $past(st.c1.output_invert)))
    else $error("run rise did not restore initial level");

  cm_high_a: assert property ( // [RQ15] [RQ19]
    (st.c1.operating_mode_sel == CTM_MODE_CMP) && a_hit
    && !run_rise && (st.c1.pin_function_sel == CTM_PF_HIGH)
    |=> timer_output_pin == !$past(st.c1.output_invert))
    else $error("compare A match did not drive pin high");

  p_silent_a: assert property ( // [RQ16]
    !is_pwm && st.c1.clear_source_sel && !compare_p_flag
    |=> !compare_p_flag)
    else $error("compare P flag raised with clear source set");

  a_zero_a: assert property ( // [RQ20]
    !is_pwm && (st.compare_a_value == '0) && !compare_a_flag
    |=> !compare_a_flag)
    else $error("compare A flag raised with zero compare A");

  a_clear_a: assert property ( // [RQ18]
    !is_pwm && st.c1.clear_source_sel && a_hit
    && st.c0.timer_run |=> (st.cnt == '0))
    else $error("compare A match did not clear counter");

  stop_hold_a: assert property ( // [RQ21]
    !st.c0.timer_run |=> (st.cnt == '0))
    else $error("counter moved while stopped");
endmodule : ctm_timer
`default_nettype wire

// file: verif/ctm_timer_tb.sv
// Self-checking bench for the compact timer: registers, PWM, compare modes
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_tb;
  import ctm_pkg::*;
  // Register access table: address, write value, expected read-back
  localparam logic [2:0] TA [6] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h2, 3'h0};
  localparam logic [7:0] TW [6] = '{8'ha5, 8'h5a, 8'hff, 8'hff, 8'hff, 8'hfe};
  localparam logic [7:0] TE [6] = '{8'ha5, 8'h5a, 8'h03, 8'h07, 8'h00, 8'h06};
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [CTM_AW-1:0] addr = '0;
  logic [CTM_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [CTM_DW-1:0] rdata;
  logic pin;
  logic pin_oe_n;
  logic flag_a;
  logic flag_p;
  int num_errors = 0;
  int checks_done = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ctm_timer #(.PRE_W(3)) i_dut (
    .clk(clk),
    .nrst(nrst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .timer_output_pin(pin),
    .pin_oe_n(pin_oe_n),
    .compare_a_flag(flag_a),
    .compare_p_flag(flag_p)
  );

  // Single exit point of the run
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Case equality so an unknown never passes
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got,
               exp);
    end
  endtask : check

  // One-cycle write strobe, launched just after an edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Stop, clear flags, load compares and control, then start at divide 1
  task automatic setup(input logic [7:0] c1, input logic [9:0] a,
                       input logic [2:0] p);
    wr_reg(CTM_A_CTRL0, 8'h00);
    wr_reg(CTM_A_FLAGS, 8'h03);
    wr_reg(CTM_A_COMPARE_A_VALUE_LO, a[7:0]);
    wr_reg(CTM_A_COMPARE_A_VALUE_HI, {6'h00, a[9:8]});
    wr_reg(CTM_A_COMPARE_P_VALUE, {5'h00, p});
    wr_reg(CTM_A_CTRL1, c1);
    wr_reg(CTM_A_CTRL0, 8'h01);
  endtask : setup

  // Counts cycles at a level and level changes over a window
  task automatic watch(input int n, input logic lvl, output int hits,
                       output int flips);
    logic last;
    hits = 0;
    flips = 0;
    @(posedge clk);
    #1;
    last = pin;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (pin === lvl) hits++;
      if (pin !== last) flips++;
      last = pin;
    end
  endtask : watch

  // Bounded wait; running out ends the run as a mismatch
  task automatic wait_flag_a(input int bound);
    int n;
    n = 0;
    while (flag_a !== 1'b1 && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (flag_a !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: flag wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_flag_a

  // Period granule rule: zero stands for the full 1024 count
  function automatic int p_cycles(input logic [2:0] p);
    return (p == 3'h0) ? 1024 : int'(p) * 128;
  endfunction : p_cycles

  initial begin
    int per, duty, act, hits, flips, a, p, sw, pf, lvl, inv, cs, s;
    logic [7:0] d, d2;
    void'($urandom(24084));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and access kinds
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[2:0], d);
      check(d, 8'h00, "reset value");
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(TA[i], TW[i]);
      rd_reg(TA[i], d);
      check(d, TE[i], "read back");
    end
    // PWM: corners first, then random period, duty, polarity, pin field
    for (int i = 0; i < 12; i++) begin
      sw = $urandom_range(0, 1);
      p = $urandom_range(0, 7);
      a = $urandom_range(sw ? 64 : 0, 1023);
      pf = $urandom_range(0, 3);
      lvl = $urandom_range(0, 1);
      inv = $urandom_range(0, 1);
      cs = $urandom_range(0, 1);
      if (i < 3) begin
        sw = (i == 2);
        p = (i == 0) ? 1 : 0;
        a = (i == 0) ? 128 : (i == 1) ? 0 : 1023;
        pf = 2;
      end
      per = sw ? ((a == 0) ? 1024 : a) : p_cycles(p[2:0]);
      duty = sw ? p_cycles(p[2:0]) : a;
      act = (pf == 1) ? per : (pf != 2) ? 0 : (duty >= per) ? per : duty;
      setup({2'b10, pf[1:0], lvl[0], inv[0], sw[0], cs[0]}, a[9:0], p[2:0]);
      cyc(per + 4);
      watch(per, lvl[0] ^ inv[0], hits, flips);
      check(hits, act, "active cycles in one period");
      check(pin_oe_n, 1'b0, "pwm pin driven");
      check(sw ? flag_a : flag_p, 1'b1, "period flag");
      if (duty > 0 && duty < per) begin
        check(sw ? flag_p : flag_a, 1'b1, "duty flag");
      end
    end
    // Compare mode, every pin field, P clears at 128
    for (int i = 0; i < 4; i++) begin
      lvl = $urandom_range(0, 1);
      inv = $urandom_range(0, 1);
      a = $urandom_range(8, 100);
      setup({2'b00, i[1:0], lvl[0], inv[0], 2'b00}, a[9:0], 3'h1);
      cyc(1);
      #1;
      check(pin, lvl[0] ^ inv[0], "initial level");
      watch(256, 1'b1, hits, flips);
      // Two A matches fall in the window; the pin field decides the changes
      act = (i == 3) ? 2 : (i == 0) ? 0 : (i == 1) ? lvl : 1 - lvl;
      check(flips, act, "pin changes");
      check({flag_a, flag_p}, 2'b11, "both flags");
      wr_reg(CTM_A_CTRL0, 8'h00);
      wr_reg(CTM_A_CTRL0, 8'h01);
      cyc(1);
      #1;
      check(pin, lvl[0] ^ inv[0], "level restored by run edge");
    end
    // Clear on A in compare, timer/counter and undefined modes
    for (int m = 0; m < 3; m++) begin
      setup({(m == 0) ? 2'b00 : (m == 1) ? 2'b11 : 2'b01, 2'b11, 4'b0001},
            10'd50, 3'h1);
      wait_flag_a(80);
      for (int k = 0; k < 10; k++) begin
        rd_reg(CTM_A_CNT_LO, d);
        check(d < 8'd50, 1'b1, "counter below A");
      end
      check({flag_a, flag_p}, 2'b10, "no P flag");
      check(pin_oe_n, m != 0, "pin release");
    end
    // Compare A zero: full wrap with no A flag
    setup(8'h00, 10'd0, 3'h0);
    cyc(1100);
    check({flag_a, flag_p}, 2'b01, "wrap flags");
    // Prescaled counting rate
    s = $urandom_range(1, 3);
    setup(8'h00, 10'd0, 3'h0);
    wr_reg(CTM_A_CTRL0, {5'h00, s[1:0], 1'b1});
    rd_reg(CTM_A_CNT_LO, d);
    cyc(64);
    rd_reg(CTM_A_CNT_LO, d2);
    hits = int'(d2) - int'(d);
    check(hits >= (66 >> s) - 1 && hits <= (66 >> s) + 1, 1'b1,
          "tick rate");
    wr_reg(CTM_A_CTRL0, 8'h00);
    rd_reg(CTM_A_CNT_LO, d);
    check(d, 8'h00, "stopped counter");
    // Reset in mid-run: released pin, cleared flags and a stopped counter
    setup(8'ha8, 10'd64, 3'h1);
    cyc(200);
    nrst <= 1'b0;
    cyc(2);
    #1;
    check({pin_oe_n, flag_a, flag_p, pin}, 4'h8, "mid-run reset");
    @(posedge clk);
    nrst <= 1'b1;
    rd_reg(CTM_A_CNT_LO, d);
    check(d, 8'h00, "counter after reset");
    report_and_stop();
  end
endmodule : ctm_timer_tb
`default_nettype wire
